// >>> core/dac_ctrl_pkg.sv
// Package holding command codes, field positions, reset values, bus address and readback slots for the DAC control
package dac_ctrl_pkg;

	// Frame layout
	localparam int FRAME_BITS      = 24;
	localparam int CMD_MSB         = 23;
	localparam int CMD_LSB         = 20;
	localparam int SEL_MSB         = 19;
	localparam int SEL_LSB         = 16;
	localparam int DATA_MSB        = 15;
	localparam int DATA_LSB        = 4;
	localparam int PD_B_MSB        = 7;
	localparam int PD_B_LSB        = 6;
	localparam int PD_A_MSB        = 1;
	localparam int PD_A_LSB        = 0;
	localparam int MASK_B_BIT      = 3;
	localparam int MASK_A_BIT      = 0;
	localparam int SEL_B_BIT       = 3;
	localparam int SEL_A_BIT       = 0;

	// Command codes
	localparam logic [3:0] CMD_NOP       = 4'h0;
	localparam logic [3:0] CMD_WR_INPUT  = 4'h1;
	localparam logic [3:0] CMD_UPDATE    = 4'h2;
	localparam logic [3:0] CMD_WR_UPDATE = 4'h3;
	localparam logic [3:0] CMD_PWR_DOWN  = 4'h4;
	localparam logic [3:0] CMD_LD_MASK   = 4'h5;

	// Power-down encodings
	localparam logic [1:0] PD_NORMAL     = 2'h0;
	localparam logic [1:0] PD_1K_GND     = 2'h1;
	localparam logic [1:0] PD_100K_GND   = 2'h2;
	localparam logic [1:0] PD_TRISTATE   = 2'h3;

	// Reset values
	localparam logic [3:0]  LOAD_MASK_RESET = 4'h0;
	localparam logic [7:0]  PD_RESET        = 8'h3c;
	localparam logic [11:0] CODE_RESET      = 12'h000;

	// Bus address: upper bits arbitrary neutral value
	localparam logic [4:0] ADDR_HI = 5'h0c;

	// Readback byte slots per cycle: A hi, A lo, four fillers, B hi, B lo
	localparam logic [2:0] SLOT_LAST = 3'h7;
	localparam logic [2:0] SLOT_B_HI = 3'h6;
	localparam logic [2:0] SLOT_B_LO = 3'h7;
	localparam logic [2:0] SLOT_A_HI = 3'h0;
	localparam logic [2:0] SLOT_A_LO = 3'h1;

endpackage

// >>> core/dual_dac_update_control.sv
// Top: frame decode, input and DAC registers, power-down and load-strobe mask
// What this block does
// - Write address, control byte, restart, read
// - First return channel A (channel B when select is 1000), high byte first
// - Then four fillers, then channel B bytes
// - Auto-increment wraps B to A until NACK
// - Command 0100 loads power-down modes
// - Mode 00 normal, 01 1k, 10 100k, 11 open
// - B mode bits 7:6, A bits 1:0
// - Powered-down output off amplifier, resistor or open
// - Power-down keeps and accepts DAC register updates
// - Separate input and DAC register per channel
// - Strobe low: input write also loads DAC
// - Strobe falling edge transfers both channels
// - Command 0101 writes mask from bits 3:0
// - Mask resets to zero
// - Masked channel ignores strobe transitions
// - Masked channel sees strobe as high
// - Mask bit 3 is B, bit 0 A
// - Frame: command, select, 12 data, four spare
// - Select 0001 A, 1000 B, 1001 both
// - 0010 copies input to DAC; 0011 writes DAC
// - Both selected: readback starts at A
`timescale 1ns/1ps
`default_nettype none
module dual_dac_update_control
	import dac_ctrl_pkg::*;
(
	// System clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Serial bus pins
	input  wire logic        scl_clk,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic [1:0]  addr_pins,
	// Load strobe pin
	input  wire logic        load_strobe_n,
	// DAC codes and output stage control
	output logic [11:0]      dac_code_a,
	output logic [11:0]      dac_code_b,
	output logic             amp_connect_a,
	output logic             amp_connect_b,
	output logic [1:0]       pd_mode_a,
	output logic [1:0]       pd_mode_b
);
	frame_if fif ();

	logic [2:0]  tgl_sync;
	logic [2:0]  ld_sync;
	logic        frame_ev;
	logic        ld_fall;
	logic        ld_low;
	logic [3:0]  cmd;
	logic [3:0]  sel;
	logic [11:0] data;
	logic        hit_a;
	logic        hit_b;
	logic [3:0]  load_strobe_mask;
	logic [7:0]  power_down_mode_control;
	logic [11:0] input_a;
	logic [11:0] input_b;
	logic        eff_low_a;
	logic        eff_low_b;
	logic        fall_a;
	logic        fall_b;
	logic        wr_in_a;
	logic        wr_in_b;
	logic        dac_w_a;
	logic        dac_w_b;
	logic        dac_u_a;
	logic        dac_u_b;
	logic        valid_sel;

	serial_link u_link (
		.scl_clk   (scl_clk),
		.reset_n   (reset_n),
		.sda_in    (sda_in),
		.sda_out   (sda_out),
		.sda_oe    (sda_oe),
		.addr_pins (addr_pins),
		.fif       (fif)
	);

	// Synchronise the frame toggle and the strobe pin
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tgl_sync <= 3'h0;
			ld_sync  <= 3'h7;
		end else begin
			tgl_sync <= {tgl_sync[1:0], fif.frame_tgl};
			ld_sync  <= {ld_sync[1:0], load_strobe_n};
		end
	end

	// Decode; the frame word is stable once the toggle is seen
	assign frame_ev  = tgl_sync[2] ^ tgl_sync[1];
	assign ld_low    = ~ld_sync[1];
	assign ld_fall   = ld_sync[2] & ~ld_sync[1];
	assign cmd       = fif.frame[CMD_MSB:CMD_LSB];
	assign sel       = fif.frame[SEL_MSB:SEL_LSB];
	assign data      = fif.frame[DATA_MSB:DATA_LSB];
	assign valid_sel = (sel == 4'h1) || (sel == 4'h8) || (sel == 4'h9);
	assign hit_a     = valid_sel & sel[SEL_A_BIT];
	assign hit_b     = valid_sel & sel[SEL_B_BIT];

	// Channel sees strobe as high when masked
	assign eff_low_a = ld_low & ~load_strobe_mask[MASK_A_BIT];
	assign eff_low_b = ld_low & ~load_strobe_mask[MASK_B_BIT];
	assign fall_a    = ld_fall & ~load_strobe_mask[MASK_A_BIT];
	assign fall_b    = ld_fall & ~load_strobe_mask[MASK_B_BIT];

	// Register write strobes
	assign wr_in_a = frame_ev & hit_a & ((cmd == CMD_WR_INPUT) || (cmd == CMD_WR_UPDATE));
	assign wr_in_b = frame_ev & hit_b & ((cmd == CMD_WR_INPUT) || (cmd == CMD_WR_UPDATE));
	assign dac_w_a = frame_ev & hit_a & ((cmd == CMD_WR_UPDATE) ||
	                 ((cmd == CMD_WR_INPUT) & eff_low_a));
	assign dac_w_b = frame_ev & hit_b & ((cmd == CMD_WR_UPDATE) ||
	                 ((cmd == CMD_WR_INPUT) & eff_low_b));
	assign dac_u_a = (frame_ev & hit_a & (cmd == CMD_UPDATE)) | fall_a;
	assign dac_u_b = (frame_ev & hit_b & (cmd == CMD_UPDATE)) | fall_b;

	// Input registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			input_a <= CODE_RESET;
			input_b <= CODE_RESET;
		end else begin
			if (wr_in_a) input_a <= data;
			if (wr_in_b) input_b <= data;
		end
	end
	assign fif.input_a = input_a;
	assign fif.input_b = input_b;

	// DAC registers, updated regardless of power-down
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dac_code_a <= CODE_RESET;
			dac_code_b <= CODE_RESET;
		end else begin
			if (dac_w_a) dac_code_a <= data;
			else if (dac_u_a) dac_code_a <= input_a;
			if (dac_w_b) dac_code_b <= data;
			else if (dac_u_b) dac_code_b <= input_b;
		end
	end

	// Power-down and mask registers; reserved codes change nothing
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			power_down_mode_control <= PD_RESET;
			load_strobe_mask        <= LOAD_MASK_RESET;
		end else if (frame_ev && !cmd[3]) begin
			if (cmd == CMD_PWR_DOWN) power_down_mode_control <= fif.frame[7:0];
			if (cmd == CMD_LD_MASK) load_strobe_mask <= fif.frame[3:0];
		end
	end

	// Output stage: any nonzero mode detaches the amplifier
	assign pd_mode_a     = power_down_mode_control[PD_A_MSB:PD_A_LSB];
	assign pd_mode_b     = power_down_mode_control[PD_B_MSB:PD_B_LSB];
	assign amp_connect_a = pd_mode_a == PD_NORMAL;
	assign amp_connect_b = pd_mode_b == PD_NORMAL;

	// Assertions
	a_mask_blocks_a: assert property (@(posedge clock) disable iff (!reset_n)
		(load_strobe_mask[MASK_A_BIT] && !frame_ev) |=> $stable(dac_code_a))
		else $error("masked channel A changed on strobe");
	a_fall_loads_b: assert property (@(posedge clock) disable iff (!reset_n)
		(fall_b && !frame_ev) |=> dac_code_b == $past(input_b))
		else $error("strobe edge did not load channel B");
	a_reserved_noop: assert property (@(posedge clock) disable iff (!reset_n)
		(frame_ev && cmd[3]) |=> $stable(power_down_mode_control) && $stable(input_a))
		else $error("reserved command changed state");
	a_mask_write: assert property (@(posedge clock) disable iff (!reset_n)
		(frame_ev && cmd == CMD_LD_MASK) |=> load_strobe_mask == $past(fif.frame[3:0]))
		else $error("mask not written");
	a_pd_write: assert property (@(posedge clock) disable iff (!reset_n)
		(frame_ev && cmd == CMD_PWR_DOWN) |=> pd_mode_b == $past(fif.frame[7:6]))
		else $error("power-down field not loaded");
	a_amp_detach: assert property (@(posedge clock) disable iff (!reset_n)
		amp_connect_a == (pd_mode_a == PD_NORMAL))
		else $error("amplifier link wrong");
	a_wr_update: assert property (@(posedge clock) disable iff (!reset_n)
		(frame_ev && hit_a && cmd == CMD_WR_UPDATE) |=> dac_code_a == $past(data))
		else $error("write-and-update missed channel A");
	a_input_only: assert property (@(posedge clock) disable iff (!reset_n)
		(frame_ev && hit_b && cmd == CMD_WR_INPUT && !eff_low_b && !fall_b)
		|=> $stable(dac_code_b) && input_b == $past(data))
		else $error("input-only write wrong");

	c_strobe_load: cover property (@(posedge clock) disable iff (!reset_n) fall_a && fall_b);
	c_pd_tri: cover property (@(posedge clock) disable iff (!reset_n) pd_mode_b == PD_TRISTATE);
	c_mask_set: cover property (@(posedge clock) disable iff (!reset_n) load_strobe_mask == 4'h9);
endmodule // dual_dac_update_control
`default_nettype wire

// >>> core/frame_if.sv
// Interface carrying completed write frames and readback data between the two domains
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
	logic [23:0] frame;      // Stable frame word, held by the link side
	logic        frame_tgl;  // Toggles once per completed frame
	logic [11:0] input_a;    // Input register contents, system domain
	logic [11:0] input_b;

	modport link (output frame, output frame_tgl, input input_a, input input_b);
	modport core (input frame, input frame_tgl, output input_a, output input_b);
endinterface
`default_nettype wire

// >>> core/serial_link.sv
// Two-wire bus slave on the serial clock: receives frames and serves readback
`timescale 1ns/1ps
`default_nettype none
module serial_link
	import dac_ctrl_pkg::*;
(
	// Link clock and reset
	input  wire logic scl_clk,
	input  wire logic reset_n,
	// Data line and address straps
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic [1:0] addr_pins,
	// Toward the system domain
	frame_if.link     fif
);
	logic [7:0]  shreg;
	logic [3:0]  bitcnt;
	logic [1:0]  bytecnt;
	logic        active;
	logic        reading;
	logic        addr_hit;
	logic [2:0]  slot;
	logic        start_b_sel;
	logic [7:0]  tx_byte;
	logic [23:0] acc;
	logic        start_seen;
	logic        start_tgl;
	logic        start_tgl_q;
	logic        stop_tgl;
	logic        stop_tgl_q;

	// Start and stop are SDA edges while SCL is high
	always_ff @(negedge sda_in or negedge reset_n) begin
		if (!reset_n) start_tgl <= 1'b0;
		else if (scl_clk) start_tgl <= ~start_tgl;
	end
	always_ff @(posedge sda_in or negedge reset_n) begin
		if (!reset_n) stop_tgl <= 1'b0;
		else if (scl_clk) stop_tgl <= ~stop_tgl;
	end
	assign start_seen = start_tgl != start_tgl_q;

	// Address byte sits whole in the shift register from the eighth bit on
	assign addr_hit = shreg[7:1] == {ADDR_HI, addr_pins};

	// Byte being shifted out during read: A, four fillers, B, wrapping
	// Input registers only move after a write frame, never inside a read
	assign tx_byte = (slot == SLOT_A_HI) ? {4'h0, fif.input_a[11:8]} :
	                 (slot == SLOT_A_LO) ? fif.input_a[7:0] :
	                 (slot == SLOT_B_HI) ? {4'h0, fif.input_b[11:8]} :
	                 (slot == SLOT_B_LO) ? fif.input_b[7:0] : 8'h00;

	// Receive on rising SCL; count bits and bytes
	always_ff @(posedge scl_clk or negedge reset_n) begin
		if (!reset_n) begin
			shreg <= 8'h00; bitcnt <= 4'h0; bytecnt <= 2'h0; active <= 1'b0;
			reading <= 1'b0; start_tgl_q <= 1'b0; stop_tgl_q <= 1'b0;
			slot <= 3'h0; start_b_sel <= 1'b0; acc <= 24'h000000;
			fif.frame <= 24'h000000; fif.frame_tgl <= 1'b0;
		end else begin
			start_tgl_q <= start_tgl;
			stop_tgl_q  <= stop_tgl;
			if (stop_tgl != stop_tgl_q) active <= 1'b0;
			if (start_seen) begin
				shreg <= {7'h00, sda_in}; bitcnt <= 4'h1; active <= 1'b1;
				bytecnt <= 2'h0; reading <= 1'b0;
			end else if (bitcnt == 4'h8) begin
				bitcnt <= 4'h0; // Ninth clock: acknowledge
				if (!active || (bytecnt == 2'h0 && !addr_hit)) active <= 1'b0;
				else if (bytecnt == 2'h0) begin
					reading <= shreg[0];
					slot <= start_b_sel ? SLOT_B_HI : SLOT_A_HI;
				end else if (reading) begin
					if (sda_in) active <= 1'b0;
					else slot <= slot + 3'h1;
				end else begin
					acc <= {acc[15:0], shreg};
					if (bytecnt == 2'h1) start_b_sel <= shreg[SEL_B_BIT] & ~shreg[SEL_A_BIT];
					if (bytecnt == 2'h3) begin
						fif.frame <= {acc[15:0], shreg};
						fif.frame_tgl <= ~fif.frame_tgl;
					end
				end
				if (bytecnt != 2'h3) bytecnt <= bytecnt + 2'h1;
				else bytecnt <= 2'h1;
			end else begin
				shreg <= {shreg[6:0], sda_in};
				bitcnt <= bitcnt + 4'h1;
			end
		end
	end

	// Drive data and acknowledge on falling SCL
	always_ff @(negedge scl_clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_out <= 1'b0; sda_oe <= 1'b0;
		end else begin
			// Acknowledge only our own address and the bytes that follow it
			if (active && bitcnt == 4'h8 && !reading && (bytecnt != 2'h0 || addr_hit)) begin
				sda_out <= 1'b0; sda_oe <= 1'b1;
			end else if (active && reading && bitcnt != 4'h8) begin
				sda_out <= 1'b0;
				sda_oe  <= ~tx_byte[3'h7 - bitcnt[2:0]];
			end else begin
				sda_out <= 1'b0; sda_oe <= 1'b0;
			end
		end
	end
endmodule // serial_link
`default_nettype wire

// >>> verif/bus_master_model.sv
// Two-wire bus master model that drives frames on its own link clock
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	// Bus wires
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda_level
);
	localparam realtime Q = 31.25; // Quarter of the 125 ns link period

	// Bus idles released, clock parked high between frames
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// One bit: data changes mid-low, sampled mid-high
	task automatic bit_io(input logic b, output logic s);
		#Q sda_pull = ~b;
		#Q scl = 1'b1;
		#Q s = sda_level;
		#Q scl = 1'b0;
	endtask

	// Start or repeated start: data falls while clock is high
	task automatic start();
		#Q sda_pull = 1'b0;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b1;
		#Q scl = 1'b0;
	endtask

	// Stop: data rises while clock is high, then the clock stands still
	task automatic stop();
		#Q sda_pull = 1'b1;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b0;
		#Q;
	endtask

	// Byte out, MSB first, then the device's acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// Byte in, then acknowledge or a closing not-acknowledge
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, s);
	endtask
endmodule // bus_master_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the dual DAC update control
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
	$display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_top
	import dac_ctrl_pkg::*;
;
	logic        clock, reset_n, scl, sda_pull, sda_oe, load_strobe_n;
	logic [11:0] dac_code_a, dac_code_b;
	logic        amp_connect_a, amp_connect_b;
	logic [1:0]  pd_mode_a, pd_mode_b;
	int          mismatches, n_tests;
	wire         sda_level = ~(sda_pull | sda_oe); // Open-drain line with pull-up

	dual_dac_update_control i_dual_dac_update_control (.clock, .reset_n, .scl_clk(scl),
		.sda_in(sda_level), .sda_out(), .sda_oe, .addr_pins(2'h2), .load_strobe_n,
		.dac_code_a, .dac_code_b, .amp_connect_a, .amp_connect_b, .pd_mode_a, .pd_mode_b);
	bus_master_model mst (.scl, .sda_pull, .sda_level);

	// System clock, 4 ns
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Verdict and end of run
	task automatic close_out();
		if (mismatches == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Full write frame: address, command byte, two data bytes
	task automatic wframe(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
		logic [3:0] a;
		mst.start();
		mst.wbyte({ADDR_HI, 2'h2, 1'b0}, a[0]);
		mst.wbyte({c, s}, a[1]);
		mst.wbyte(d[15:8], a[2]);
		mst.wbyte(d[7:0], a[3]);
		mst.stop();
		`CHK(a, 4'hf)
		repeat (8) @(negedge clock);
	endtask

	// Move the strobe pin and let the synchroniser catch up
	task automatic strobe(input logic v);
		@(negedge clock);
		load_strobe_n = v;
		repeat (6) @(negedge clock);
	endtask

	// Reset state and a foreign address
	task automatic t_reset();
		logic a;
		`CHK({dac_code_a, dac_code_b}, {CODE_RESET, CODE_RESET})
		`CHK({pd_mode_b, pd_mode_a}, {PD_RESET[7:6], PD_RESET[1:0]})
		`CHK({amp_connect_b, amp_connect_a}, 2'h3)
		mst.start();
		mst.wbyte({ADDR_HI, 2'h1, 1'b0}, a);
		mst.stop();
		`CHK(a, 1'b0)
	endtask

	// Deferred update by strobe edge, then transparent update with strobe low
	task automatic t_strobe();
		wframe(CMD_WR_INPUT, 4'h9, 16'h5a30);
		`CHK({dac_code_a, dac_code_b}, 24'h000000)
		strobe(1'b0);
		`CHK({dac_code_a, dac_code_b}, 24'h5a35a3)
		wframe(CMD_WR_INPUT, 4'h8, 16'h0c70);
		`CHK({dac_code_a, dac_code_b}, 24'h5a30c7)
		strobe(1'b1);
		wframe(CMD_WR_UPDATE, 4'h9, 16'h3e10);
		`CHK({dac_code_a, dac_code_b}, 24'h3e13e1)
		wframe(CMD_WR_INPUT, 4'h1, 16'h7770);
		`CHK(dac_code_a, 12'h3e1)
		wframe(CMD_UPDATE, 4'h9, 16'h0000);
		`CHK({dac_code_a, dac_code_b}, 24'h7773e1)
	endtask

	// Mask each channel in turn against strobe edges and a low strobe
	task automatic t_mask();
		logic [3:0] mk;
		for (int i = 0; i < 2; i++) begin
			mk = i ? 4'h8 : 4'h1;
			wframe(CMD_WR_UPDATE, 4'h9, 16'h2220);
			wframe(CMD_LD_MASK, 4'h6, {12'h000, mk});
			wframe(CMD_WR_INPUT, 4'h9, 16'h4440);
			strobe(1'b0);
			`CHK(dac_code_a, mk[0] ? 12'h222 : 12'h444)
			`CHK(dac_code_b, mk[3] ? 12'h222 : 12'h444)
			wframe(CMD_WR_INPUT, 4'h9, 16'h6660);
			`CHK({dac_code_a, dac_code_b}, {mk[0] ? 12'h222 : 12'h666, mk[3] ? 12'h222 : 12'h666})
			strobe(1'b1);
			wframe(CMD_UPDATE, 4'h9, 16'h0000);
			`CHK({dac_code_a, dac_code_b}, 24'h666666)
		end
		wframe(CMD_LD_MASK, 4'h0, 16'h0000);
	endtask

	// Every power-down mode on both channels, with DAC writes meanwhile
	task automatic t_power();
		logic [1:0] md;
		wframe(CMD_WR_UPDATE, 4'h8, 16'h9d20);
		for (int k = 0; k < 4; k++) begin
			md = k[1:0];
			wframe(CMD_PWR_DOWN, 4'h0, {8'h00, ~md, 4'hf, md});
			`CHK({pd_mode_b, pd_mode_a}, {~md, md})
			`CHK({amp_connect_b, amp_connect_a}, {md == 2'h3, md == PD_NORMAL})
			wframe(CMD_WR_UPDATE, 4'h1, {10'h100, md, 4'h0});
			`CHK({dac_code_a, dac_code_b}, {10'h100, md, 12'h9d2})
		end
		wframe(CMD_PWR_DOWN, 4'h0, 16'h003c);
		for (int c = 8; c < 16; c++) begin
			wframe(c[3:0], 4'h9, 16'hfff0);
			`CHK({dac_code_a, dac_code_b, pd_mode_a, pd_mode_b}, 28'h4039d20)
		end
	endtask

	// Readback run of ten bytes from a chosen starting channel
	task automatic t_read(input logic [7:0] ctl, input int first);
		logic [2:0] a;
		logic [7:0] q;
		logic [7:0] slot [8];
		slot = '{8'h0a, 8'hbc, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h23};
		mst.start();
		mst.wbyte({ADDR_HI, 2'h2, 1'b0}, a[0]);
		mst.wbyte(ctl, a[1]);
		mst.start();
		mst.wbyte({ADDR_HI, 2'h2, 1'b1}, a[2]);
		`CHK(a, 3'h7)
		for (int i = 0; i < 10; i++) begin
			mst.rbyte(i == 9, q);
			`CHK(q, slot[(first + i) % 8])
		end
		mst.stop();
	endtask

	// Main sequence
	initial begin
		reset_n = 1'b0;
		load_strobe_n = 1'b1;
		repeat (20) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		t_reset();
		t_strobe();
		t_mask();
		t_power();
		wframe(CMD_WR_UPDATE, 4'h1, 16'habc0);
		wframe(CMD_WR_UPDATE, 4'h8, 16'h1230);
		t_read(8'h09, 0);
		t_read(8'h08, 6);
		close_out();
	end

	// Watchdog against a hung bus
	initial begin
		#300000;
		mismatches++;
		close_out();
	end
endmodule // tb_top
`default_nettype wire
